// [hdl/rmvs_pkg.sv]
// Shared constants and types for the regulator mode and voltage selector.
package rmvs_pkg;
	localparam int NUM_BUCK = 4;
	localparam int NUM_LIN = 10;
	localparam int NUM_LPV = 6;
	localparam int BUCK_VW = 7;
	localparam int LIN_VW = 5;
	localparam int ALIVE_VW = 4;
	// Register byte offsets.
	localparam logic [7:0] OFS_BUCK_RUN = 8'h00;
	localparam logic [7:0] OFS_BUCK_SLEEP = 8'h04;
	localparam logic [7:0] OFS_BUCK_MODE = 8'h08;
	localparam logic [7:0] OFS_LIN_MODE = 8'h0C;
	localparam logic [7:0] OFS_ALIVE = 8'h10;
	localparam logic [7:0] OFS_HWCTL = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_LIN_V0 = 8'h20;
	// Buck code for 0.8 V and 1.55 V on the 0.6 V base, 12.5 mV steps.
	localparam logic [6:0] BUCK_CODE_0V80 = 7'h10;
	localparam logic [6:0] BUCK_CODE_1V55 = 7'h4C;
	localparam logic [3:0] ALIVE_CODE_MIN = 4'h0;
	localparam logic [3:0] ALIVE_CODE_MAX = 4'hF;
	// Buck steps per alive step, and half of it for nearest rounding.
	localparam logic [6:0] ALIVE_STEP = 7'h04;
	localparam logic [6:0] ALIVE_HALF = 7'h02;
	localparam int SLEW_CYCLES = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		RMVS_FORCED_CONTINUOUS,
		RMVS_AUTO,
		RMVS_HYST,
		RMVS_LINEAR
	} rmvs_buck_mode_t;
endpackage

// [hdl/rmvs_alive_track.sv]
// Converts a buck voltage code into the nearest alive regulator code.
`timescale 1ns/1ps
`default_nettype none
module rmvs_alive_track (
	input wire logic [6:0] i_buck_code,
	input wire logic i_buck_on,
	output logic [3:0] o_alive_code
);
	logic [6:0] rel;
	logic [6:0] q;
	always_comb begin
		rel = 7'h00;
		q = 7'h00;
		if (!i_buck_on || i_buck_code <= rmvs_pkg::BUCK_CODE_0V80) begin
			o_alive_code = rmvs_pkg::ALIVE_CODE_MIN;
		end else if (i_buck_code >= rmvs_pkg::BUCK_CODE_1V55) begin
			o_alive_code = rmvs_pkg::ALIVE_CODE_MAX;
		end else begin
			rel = i_buck_code - rmvs_pkg::BUCK_CODE_0V80 + rmvs_pkg::ALIVE_HALF;
			q = rel >> 2;
			o_alive_code = q[3:0];
		end
	end
endmodule
`default_nettype wire

// [hdl/rmvs_slew.sv]
// Tracks a voltage slew on one buck and drives its done flag.
`timescale 1ns/1ps
`default_nettype none
module rmvs_slew (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [6:0] i_code,
	output logic o_done
);
	typedef struct packed {
		logic [6:0] last;
		logic [4:0] cnt;
	} rmvs_slew_t;
	rmvs_slew_t r, next_r;
	always_comb begin
		next_r = r;
		if (i_code != r.last) begin
			next_r.last = i_code;
			next_r.cnt = 5'(rmvs_pkg::SLEW_CYCLES);
		end else if (r.cnt != 5'h00) begin
			next_r.cnt = r.cnt - 5'h01;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign o_done = (r.cnt == 5'h00) && (i_code == r.last);
	chk_done_low_slew: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_code != r.last) |-> !o_done ##1 !o_done) else $error("done high during code change");
endmodule
`default_nettype wire

// [hdl/rmvs_top.sv]
// Regulator operating mode and voltage code selector with AXI4-Lite registers.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rmvs_top (
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic I_SLEEP,
	input wire logic [3:0] I_HWCTL,
	input wire logic [3:0] I_BUCK_ON,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [7:0] O_BUCK_OPMODE,
	output logic [27:0] O_BUCK_VOLTAGE_CODE,
	output logic [9:0] O_LINREG_LOWPOWER,
	output logic [5:0] O_LINREG_LP_VARIANT,
	output logic [49:0] O_LINREG_VOLTAGE_CODE,
	output logic [3:0] O_ALIVE_VOLTAGE_CODE,
	output logic [1:0] O_SLEW_DONE
);
	typedef struct packed {
		logic [27:0] buck_run_state_voltage_code;
		logic [27:0] buck_sleep_state_voltage_code;
		logic [7:0] buck_run_state_opmode;
		logic [7:0] buck_sleep_state_opmode;
		logic [9:0] linreg_run_state_opmode;
		logic [9:0] linreg_sleep_state_opmode;
		logic [5:0] linreg_lowpower_variant;
		logic [49:0] linreg_run_state_voltage_code;
		logic [49:0] linreg_sleep_state_voltage_code;
		logic alive_reg_track_select;
		logic [3:0] alive_reg_run_voltage_code;
		logic [3:0] alive_reg_sleep_voltage_code;
		logic [27:0] buck_hwctl_voltage_code;
		logic [7:0] buck_hwctl_opmode;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} rmvs_state_t;

	rmvs_state_t r, next_r;
	logic [3:0] alive_tracked;
	logic [31:0] rd_word;
	logic rd_ok;
	logic [31:0] wr_word;
	logic wr_ok;
	logic [7:0] lin_idx;
	logic [6:0] buck_one_sel;

	assign buck_one_sel = I_SLEEP ? r.buck_sleep_state_voltage_code[6:0]
		: r.buck_run_state_voltage_code[6:0];

	rmvs_alive_track u_track (
		.i_buck_code(buck_one_sel),
		.i_buck_on(I_BUCK_ON[0]),
		.o_alive_code(alive_tracked)
	);

	// Register read mux; linear voltage words sit one per regulator from OFS_LIN_V0.
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		lin_idx = (I_ARADDR - rmvs_pkg::OFS_LIN_V0) >> 2;
		unique case (I_ARADDR)
			rmvs_pkg::OFS_BUCK_RUN: rd_word = {4'h0, r.buck_run_state_voltage_code};
			rmvs_pkg::OFS_BUCK_SLEEP: rd_word = {4'h0, r.buck_sleep_state_voltage_code};
			rmvs_pkg::OFS_BUCK_MODE: rd_word = {16'h0000, r.buck_sleep_state_opmode,
				r.buck_run_state_opmode};
			rmvs_pkg::OFS_LIN_MODE: rd_word = {6'h00, r.linreg_lowpower_variant,
				r.linreg_sleep_state_opmode, r.linreg_run_state_opmode};
			rmvs_pkg::OFS_ALIVE: rd_word = {23'h000000, r.alive_reg_track_select,
				r.alive_reg_sleep_voltage_code, r.alive_reg_run_voltage_code};
			rmvs_pkg::OFS_HWCTL: rd_word = {r.buck_hwctl_opmode, 24'h000000}
				| {4'h0, r.buck_hwctl_voltage_code};
			rmvs_pkg::OFS_STATUS: rd_word = {24'h000000, O_ALIVE_VOLTAGE_CODE,
				O_SLEW_DONE, 1'b0, I_SLEEP};
			default: begin
				if (I_ARADDR[1:0] == 2'h0 && I_ARADDR >= rmvs_pkg::OFS_LIN_V0
					&& lin_idx < 8'(rmvs_pkg::NUM_LIN)) begin
					rd_word = {22'h000000,
						r.linreg_sleep_state_voltage_code[lin_idx*5 +: 5],
						r.linreg_run_state_voltage_code[lin_idx*5 +: 5]};
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	always_comb begin
		next_r = r;
		wr_word = r.w_data;
		wr_ok = 1'b1;
		if (I_AWVALID && O_AWREADY) begin
			next_r.aw_got = 1'b1;
			next_r.aw_addr = I_AWADDR;
		end
		if (I_WVALID && O_WREADY) begin
			next_r.w_got = 1'b1;
			next_r.w_data = I_WDATA;
			next_r.w_strb = I_WSTRB;
		end
		if (r.bvalid && I_BREADY) begin
			next_r.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			if (r.w_strb != 4'hF) begin
				wr_ok = 1'b0;
			end else begin
				unique case (r.aw_addr)
					rmvs_pkg::OFS_BUCK_RUN: next_r.buck_run_state_voltage_code = wr_word[27:0];
					rmvs_pkg::OFS_BUCK_SLEEP: next_r.buck_sleep_state_voltage_code = wr_word[27:0];
					rmvs_pkg::OFS_BUCK_MODE: begin
						next_r.buck_run_state_opmode = wr_word[7:0];
						next_r.buck_sleep_state_opmode = wr_word[15:8];
					end
					rmvs_pkg::OFS_LIN_MODE: begin
						next_r.linreg_run_state_opmode = wr_word[9:0];
						next_r.linreg_sleep_state_opmode = wr_word[19:10];
						next_r.linreg_lowpower_variant = wr_word[25:20];
					end
					rmvs_pkg::OFS_ALIVE: begin
						next_r.alive_reg_run_voltage_code = wr_word[3:0];
						next_r.alive_reg_sleep_voltage_code = wr_word[7:4];
						next_r.alive_reg_track_select = wr_word[8];
					end
					rmvs_pkg::OFS_HWCTL: begin
						next_r.buck_hwctl_voltage_code = wr_word[27:0];
						next_r.buck_hwctl_opmode = {wr_word[31:28], 4'h0};
					end
					default: begin
						if (r.aw_addr[1:0] == 2'h0 && r.aw_addr >= rmvs_pkg::OFS_LIN_V0
							&& ((r.aw_addr - rmvs_pkg::OFS_LIN_V0) >> 2) < 8'(rmvs_pkg::NUM_LIN)) begin
							for (int i = 0; i < rmvs_pkg::NUM_LIN; i++) begin
								if (8'(i) == ((r.aw_addr - rmvs_pkg::OFS_LIN_V0) >> 2)) begin
									next_r.linreg_run_state_voltage_code[i*5 +: 5] = wr_word[4:0];
									next_r.linreg_sleep_state_voltage_code[i*5 +: 5] = wr_word[9:5];
								end
							end
						end else begin
							wr_ok = 1'b0;
						end
					end
				endcase
			end
			next_r.bresp = wr_ok ? rmvs_pkg::RESP_OKAY : rmvs_pkg::RESP_SLVERR;
		end
		if (r.rvalid && I_RREADY) begin
			next_r.rvalid = 1'b0;
		end
		if (I_ARVALID && O_ARREADY) begin
			next_r.rvalid = 1'b1;
			next_r.rdata = rd_word;
			next_r.rresp = rd_ok ? rmvs_pkg::RESP_OKAY : rmvs_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// HWCTL mode only holds upper nibble per 32-bit word limit; one bit pair per buck.
	assign O_AWREADY = !r.aw_got;
	assign O_WREADY = !r.w_got;
	assign O_BVALID = r.bvalid;
	assign O_BRESP = r.bresp;
	assign O_ARREADY = !r.rvalid;
	assign O_RVALID = r.rvalid;
	assign O_RDATA = r.rdata;
	assign O_RRESP = r.rresp;

	genvar g;
	generate
		for (g = 0; g < rmvs_pkg::NUM_BUCK; g++) begin : g_buck
			always_comb begin
				if (I_HWCTL[g]) begin
					O_BUCK_OPMODE[g*2 +: 2] = r.buck_hwctl_opmode[g*2 +: 2];
					O_BUCK_VOLTAGE_CODE[g*7 +: 7] = r.buck_hwctl_voltage_code[g*7 +: 7];
				end else if (I_SLEEP) begin
					O_BUCK_OPMODE[g*2 +: 2] = r.buck_sleep_state_opmode[g*2 +: 2];
					O_BUCK_VOLTAGE_CODE[g*7 +: 7] = r.buck_sleep_state_voltage_code[g*7 +: 7];
				end else begin
					O_BUCK_OPMODE[g*2 +: 2] = r.buck_run_state_opmode[g*2 +: 2];
					O_BUCK_VOLTAGE_CODE[g*7 +: 7] = r.buck_run_state_voltage_code[g*7 +: 7];
				end
			end
		end
		for (g = 0; g < rmvs_pkg::NUM_LIN; g++) begin : g_lin
			assign O_LINREG_LOWPOWER[g] = I_SLEEP ? r.linreg_sleep_state_opmode[g]
				: r.linreg_run_state_opmode[g];
			assign O_LINREG_VOLTAGE_CODE[g*5 +: 5] = I_SLEEP
				? r.linreg_sleep_state_voltage_code[g*5 +: 5]
				: r.linreg_run_state_voltage_code[g*5 +: 5];
		end
		for (g = 0; g < rmvs_pkg::NUM_LPV; g++) begin : g_lpv
			assign O_LINREG_LP_VARIANT[g] = O_LINREG_LOWPOWER[g] & r.linreg_lowpower_variant[g];
		end
		for (g = 0; g < 2; g++) begin : g_slew
			rmvs_slew u_slew (
				.i_clk(I_MCLK),
				.i_rst(I_RST),
				.i_code(O_BUCK_VOLTAGE_CODE[g*7 +: 7]),
				.o_done(O_SLEW_DONE[g])
			);
		end
	endgenerate

	assign O_ALIVE_VOLTAGE_CODE = r.alive_reg_track_select ? alive_tracked
		: (I_SLEEP ? r.alive_reg_sleep_voltage_code : r.alive_reg_run_voltage_code);

	chk_buck_sleep_sel: assert property (@(posedge I_MCLK) disable iff (I_RST)
		(I_SLEEP && !I_HWCTL[0]) |-> O_BUCK_VOLTAGE_CODE[6:0]
		== r.buck_sleep_state_voltage_code[6:0]) else $error("buck sleep code wrong");
	chk_buck_run_mode: assert property (@(posedge I_MCLK) disable iff (I_RST)
		(!I_SLEEP && !I_HWCTL[1]) |-> O_BUCK_OPMODE[3:2]
		== r.buck_run_state_opmode[3:2]) else $error("buck run mode wrong");
	chk_hwctl_override: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_HWCTL[2] |-> O_BUCK_VOLTAGE_CODE[20:14]
		== r.buck_hwctl_voltage_code[20:14]) else $error("hwctl ignored");
	chk_lin_state: assert property (@(posedge I_MCLK) disable iff (I_RST)
		$rose(I_SLEEP) |-> O_LINREG_LOWPOWER[3] == r.linreg_sleep_state_opmode[3])
		else $error("linear mode not switched");
	chk_lp_variant: assert property (@(posedge I_MCLK) disable iff (I_RST)
		!O_LINREG_LOWPOWER[0] |-> !O_LINREG_LP_VARIANT[0]) else $error("variant without low power");
	chk_lp_variant_pick: assert property (@(posedge I_MCLK) disable iff (I_RST)
		O_LINREG_LOWPOWER[1] |-> O_LINREG_LP_VARIANT[1] == r.linreg_lowpower_variant[1])
		else $error("variant bit ignored");
	chk_alive_own: assert property (@(posedge I_MCLK) disable iff (I_RST)
		(!r.alive_reg_track_select && !I_SLEEP) |-> O_ALIVE_VOLTAGE_CODE
		== r.alive_reg_run_voltage_code) else $error("alive own code wrong");
	chk_alive_floor: assert property (@(posedge I_MCLK) disable iff (I_RST)
		(r.alive_reg_track_select && !I_BUCK_ON[0]) |-> O_ALIVE_VOLTAGE_CODE == 4'h0)
		else $error("alive floor wrong");
	chk_alive_top: assert property (@(posedge I_MCLK) disable iff (I_RST)
		(r.alive_reg_track_select && I_BUCK_ON[0]
		&& buck_one_sel >= rmvs_pkg::BUCK_CODE_1V55)
		|-> O_ALIVE_VOLTAGE_CODE == rmvs_pkg::ALIVE_CODE_MAX)
		else $error("alive tracking wrong");
	chk_write_applies: assert property (@(posedge I_MCLK) disable iff (I_RST)
		(r.aw_got && r.w_got && !r.bvalid && r.w_strb == 4'hF && r.aw_addr == 8'h00)
		|=> r.buck_run_state_voltage_code == $past(r.w_data[27:0])) else $error("write lost");
endmodule
`default_nettype wire

// [testbench/regulator_mode_voltage_select_tb.sv]
// Self-checking bench for the regulator mode and voltage selector.
`timescale 1ns/1ps
`default_nettype none
module regulator_mode_voltage_select_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sleep = 1'b0;
	logic [3:0] hwctl = 4'h0;
	logic [3:0] buck_on = 4'hF;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic [3:0] wstrb = 4'hF;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, done;
	logic [31:0] rdata;
	logic [7:0] opmode;
	logic [27:0] bvcode;
	logic [9:0] lp;
	logic [5:0] lpv;
	logic [49:0] lvcode;
	logic [3:0] alive;
	int bad_count = 0;
	int n_compared = 0;
	always #2 clk = ~clk;
	rmvs_top rmvs_top_inst (.I_MCLK(clk), .I_RST(rst), .I_SLEEP(sleep), .I_HWCTL(hwctl),
		.I_BUCK_ON(buck_on), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
		.O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
		.I_RREADY(rready), .O_BUCK_OPMODE(opmode), .O_BUCK_VOLTAGE_CODE(bvcode),
		.O_LINREG_LOWPOWER(lp), .O_LINREG_LP_VARIANT(lpv), .O_LINREG_VOLTAGE_CODE(lvcode),
		.O_ALIVE_VOLTAGE_CODE(alive), .O_SLEW_DONE(done));
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Each channel drops its valid at the edge that takes it; only the bench timeout ends a wait.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk({bvalid, bresp}, {1'b1, e}); // write answer
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		chk({rvalid, rresp, rdata}, {1'b1, er, e}); // read answer
	endtask
	// Nearest 50 mV step above 0.8 V, in tenths of a millivolt, clamped to the range.
	function automatic logic [3:0] aexp(input int c);
		int v;
		v = 125 * c - 2000;
		if (v <= 0) return 4'h0;
		v = (v + 250) / 500;
		return (v > 15) ? 4'hF : 4'(v);
	endfunction
	task automatic go_sleep(input logic s);
		@(posedge clk);
		sleep <= s;
		#1;
	endtask
	task automatic t_reset;
		#1;
		chk({done, opmode, bvcode, alive, lp}, {2'h3, 50'h0}); // idle after reset
		rd(rmvs_pkg::OFS_BUCK_MODE, 32'h0, rmvs_pkg::RESP_OKAY);
	endtask
	task automatic t_buck;
		int n;
		wr(rmvs_pkg::OFS_BUCK_RUN, {4'h0, 7'h44, 7'h33, 7'h22, 7'h1B}, rmvs_pkg::RESP_OKAY);
		#1;
		chk(done, 2'h0); // slew in progress
		for (n = 0; n < 40 && done !== 2'h3; n++) @(posedge clk);
		#1;
		chk(done, 2'h3); // slew finished
		rd(rmvs_pkg::OFS_STATUS, 32'h0C, rmvs_pkg::RESP_OKAY);
		wr(rmvs_pkg::OFS_BUCK_SLEEP, {4'h0, 7'h05, 7'h06, 7'h07, 7'h2F}, rmvs_pkg::RESP_OKAY);
		// no heavier load follows this mode change, so no set-up wait is owed.
		wr(rmvs_pkg::OFS_BUCK_MODE, 32'h1BE4, rmvs_pkg::RESP_OKAY);
		rd(rmvs_pkg::OFS_BUCK_MODE, 32'h1BE4, rmvs_pkg::RESP_OKAY);
		#1;
		chk({opmode, bvcode}, {8'hE4, 7'h44, 7'h33, 7'h22, 7'h1B}); // run fields
		go_sleep(1'b1);
		chk({opmode, bvcode}, {8'h1B, 7'h05, 7'h06, 7'h07, 7'h2F}); // sleep fields
		wr(rmvs_pkg::OFS_BUCK_SLEEP, {4'h0, 7'h15, 7'h06, 7'h07, 7'h2F}, rmvs_pkg::RESP_OKAY);
		#1;
		chk(bvcode, {7'h15, 7'h06, 7'h07, 7'h2F}); // live rewrite
		go_sleep(1'b0);
	endtask
	task automatic t_lin;
		int i;
		logic [49:0] ev;
		logic [49:0] es;
		wr(rmvs_pkg::OFS_LIN_MODE, {6'h0, 6'h33, 10'h2AA, 10'h155}, rmvs_pkg::RESP_OKAY);
		for (i = 0; i < 10; i++) begin
			wr(rmvs_pkg::OFS_LIN_V0 + 8'(4 * i), {22'h0, 5'(i + 10), 5'(i)}, rmvs_pkg::RESP_OKAY);
			ev[5 * i +: 5] = 5'(i);
			es[5 * i +: 5] = 5'(i + 10);
		end
		#1;
		chk({lp, lpv, lvcode}, {10'h155, 6'h11, ev}); // run fields
		go_sleep(1'b1);
		chk({lp, lpv, lvcode}, {10'h2AA, 6'h22, es}); // sleep fields
		wr(rmvs_pkg::OFS_LIN_V0, {22'h0, 5'h1F, 5'h0}, rmvs_pkg::RESP_OKAY);
		es[4:0] = 5'h1F;
		#1;
		chk(lvcode, es); // live rewrite
		go_sleep(1'b0);
	endtask
	task automatic t_alive;
		wr(rmvs_pkg::OFS_ALIVE, 32'h095, rmvs_pkg::RESP_OKAY);
		#1;
		chk(alive, 4'h5); // own run code
		go_sleep(1'b1);
		chk(alive, 4'h9); // own sleep code
		wr(rmvs_pkg::OFS_ALIVE, 32'h195, rmvs_pkg::RESP_OKAY);
		#1;
		chk(alive, aexp(8'h2F)); // follows buck one sleep code
		go_sleep(1'b0);
		chk(alive, aexp(8'h1B)); // follows buck one run code
		// buck one is taken to switch at 2 MHz here, where codes above 1.4 V are allowed.
		wr(rmvs_pkg::OFS_BUCK_RUN, {4'h0, 7'h44, 7'h33, 7'h22, 7'h60}, rmvs_pkg::RESP_OKAY);
		#1;
		chk(alive, aexp(8'h60)); // clamp at top of range
		@(posedge clk);
		buck_on <= 4'hE;
		#1;
		chk(alive, 4'h0); // buck one disabled
		@(posedge clk);
		buck_on <= 4'hF;
	endtask
	task automatic t_hwctl;
		wr(rmvs_pkg::OFS_HWCTL, {4'h9, 7'h0A, 7'h0B, 7'h0C, 7'h0D}, rmvs_pkg::RESP_OKAY);
		@(posedge clk);
		hwctl <= 4'hF;
		#1;
		chk({opmode, bvcode}, {8'h90, 7'h0A, 7'h0B, 7'h0C, 7'h0D}); // override
		@(posedge clk);
		hwctl <= 4'h0;
		#1;
		chk({opmode, bvcode}, {8'hE4, 7'h44, 7'h33, 7'h22, 7'h60}); // override released
	endtask
	task automatic t_bus;
		// A partial strobe must be refused and leave the mode word as it was.
		@(posedge clk);
		wstrb <= 4'h3;
		wr(rmvs_pkg::OFS_BUCK_MODE, 32'h0000_0000, rmvs_pkg::RESP_SLVERR);
		wstrb <= 4'hF;
		wr(8'h1C, 32'hFFFF_FFFF, rmvs_pkg::RESP_SLVERR);
		rd(8'h1C, 32'h0, rmvs_pkg::RESP_SLVERR);
		rd(rmvs_pkg::OFS_BUCK_MODE, 32'h1BE4, rmvs_pkg::RESP_OKAY);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_buck;
		t_lin;
		t_alive;
		t_hwctl;
		t_bus;
		complete_run;
	end
	// The whole sequence needs under two hundred cycles; this span of 10000 cycles leaves ample margin.
	initial begin
		#40000;
		bad_count++;
		complete_run;
	end
endmodule
`default_nettype wire
